// File: logic/rcwd_pkg.sv
package rcwd_pkg;
    // Register map, one 8-bit register per word offset
    localparam logic [3:0] RCWD_OFS_CAUSE = 4'h0;
    localparam logic [3:0] RCWD_OFS_CLOCK = 4'h4;
    // Reset cause control field positions
    localparam int RCWD_BIT_IRQ_PRIO = 7;
    localparam int RCWD_BIT_SOFT_BOR = 6;
    localparam int RCWD_BIT_RESET_INSTR = 4;
    localparam int RCWD_BIT_WDT_EXP = 3;
    localparam int RCWD_BIT_POWERDOWN = 2;
    localparam int RCWD_BIT_POR = 1;
    localparam int RCWD_BIT_BOR = 0;
    localparam logic [7:0] RCWD_CAUSE_RESET = 8'h5C;
    localparam logic [1:0] RCWD_BOR_SOFT_MODE = 2'b01;
    // Fast oscillator frequency select; code 3'h4 stands for 1 MHz
    localparam logic [2:0] RCWD_FOSC_SEL_RESET = 3'h4;
    // Timing
    localparam int RCWD_CLK_HZ = 40_000_000;
    localparam int RCWD_OST_CYCLES = 1024;
    localparam int RCWD_PLL_WAIT_US = 2000;
    localparam int RCWD_PLL_CYCLES = RCWD_PLL_WAIT_US * (RCWD_CLK_HZ / 1_000_000);
    localparam int RCWD_CPU_WAKE_CYCLES = 4;
    localparam int RCWD_FOSC_SETTLE_CYCLES = 40;
    localparam int RCWD_PIN_FILTER_CYCLES = 4;

    typedef enum logic [2:0] {
        RCWD_OSC_LP = 3'b000,
        RCWD_OSC_XT = 3'b001,
        RCWD_OSC_HS = 3'b010,
        RCWD_OSC_HIGH_SPEED_PLL_CRYSTAL = 3'b011,
        RCWD_OSC_EXT = 3'b100,
        RCWD_OSC_RC = 3'b101,
        RCWD_OSC_FAST = 3'b110,
        RCWD_OSC_SLOW = 3'b111
    } rcwd_osc_e;

    typedef enum logic [1:0] {
        RCWD_SRC_PRIMARY = 2'b00,
        RCWD_SRC_SECONDARY = 2'b01,
        RCWD_SRC_INTERNAL = 2'b10,
        RCWD_SRC_NONE = 2'b11
    } rcwd_src_e;

    typedef struct packed {
        logic por;
        logic bor;
        logic pin_run;
        logic pin_pm;
        logic wdt;
        logic reset_instr;
        logic stack_full;
        logic stack_under;
    } rcwd_cause_s;

    typedef struct packed {
        logic wake;
        logic sleep_instr;
        logic wdt_clear_instr;
        logic wdt_timeout;
    } rcwd_event_s;
endpackage : rcwd_pkg

// File: logic/rcwd_top.sv
`timescale 1ns/10ps
// Operation
// - Primary idle wake skips oscillator start-up count
// - Non-crystal primary skips oscillator start-up count
// - Every wake waits CPU delay, then resumes
// - Start-up counts 1024 cycles; PLL waits 2 ms
// - PLL crystal wake: start-up plus PLL wait
// - Fast oscillator wake runs on, flags settled
// - CPU delay runs parallel with other delays
// - Reset sets fast oscillator to 1 MHz
// - Eight reset causes accepted; only four are distinguished
// - Bit 7 enables interrupt priority, resets 0
// - Bit 6 soft brown-out only in mode 01
// - Bit 5 always reads zero
// - Bit 4 cleared by reset instruction
// - Bit 3 set power/clear/sleep, cleared by timeout
// - Bit 2 set power/clear, cleared by sleep
// - Bit 1 cleared by power-on, firmware sets
// - Bit 0 cleared by brown-out, firmware sets
// - Brown-out bit clears on power-on, and on brown-out unless mode 00 or soft mode with bit 6 clear
// - Low pin requests reset; short pulses filtered
// - Internal resets never drive the pin
// - Disabled pin is a plain input
module rcwd_top
    import rcwd_pkg::*;
#(
    parameter int PLL_CYCLES = RCWD_PLL_CYCLES,
    parameter int PIN_FILTER = RCWD_PIN_FILTER_CYCLES
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic osc_tick_i,
    input wire rcwd_osc_e primary_mode_i,
    input wire rcwd_src_e wake_source_i,
    input wire logic primary_clock_idle_i,
    input wire rcwd_event_s event_i,
    input wire rcwd_cause_s cause_i,
    input wire logic [1:0] brownout_config_mode_i,
    input wire logic external_reset_pin_enable_i,
    input wire logic external_reset_pin_n_i,
    output logic external_reset_pin_o,
    output logic external_reset_pin_oe_o,
    output logic pin_reset_req_o,
    output logic pin_level_o,
    output logic cpu_run_o,
    output logic primary_clock_ready_flag_o,
    output logic internal_osc_stable_flag_o,
    output logic soft_brownout_enable_o,
    output logic irq_priority_enable_o,
    output logic [2:0] fast_osc_sel_o
);
    typedef enum logic [1:0] {
        RCWD_ST_IDLE = 2'b00,
        RCWD_ST_OST = 2'b01,
        RCWD_ST_PLL = 2'b10,
        RCWD_ST_DONE = 2'b11
    } rcwd_state_e;

    function automatic logic is_crystal(input rcwd_osc_e m);
        is_crystal = (m == RCWD_OSC_LP) || (m == RCWD_OSC_XT) || (m == RCWD_OSC_HS) || (m == RCWD_OSC_HIGH_SPEED_PLL_CRYSTAL);
    endfunction : is_crystal

    localparam logic [21:0] PLL_LAST = 22'(PLL_CYCLES - 1);
    localparam logic [21:0] OST_LAST = 22'(RCWD_OST_CYCLES - 1);
    localparam logic [2:0] CPU_LAST = 3'(RCWD_CPU_WAKE_CYCLES - 1);
    localparam logic [5:0] FOSC_LAST = 6'(RCWD_FOSC_SETTLE_CYCLES - 1);
    localparam logic [2:0] FILT_LAST = 3'(PIN_FILTER - 1);

    // Pin synchroniser; only stages two and three are compared
    logic pin_s1, pin_s2, pin_s3, pin_filt;
    logic [2:0] filt_cnt;
    wire pin_agree = (pin_s2 == pin_s3);
    wire pin_differs = pin_agree && (pin_s3 != pin_filt);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
        end else begin
            pin_s1 <= external_reset_pin_n_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    // A change must hold for the whole filter span before it counts
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            filt_cnt <= 3'h0;
            pin_filt <= 1'b1;
        end else if (!pin_differs) begin
            filt_cnt <= 3'h0;
        end else if (filt_cnt == FILT_LAST) begin
            filt_cnt <= 3'h0;
            pin_filt <= pin_s3;
        end else begin
            filt_cnt <= filt_cnt + 3'h1;
        end
    end
    wire next_pin_req = external_reset_pin_enable_i && !pin_filt;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pin_reset_req_o <= 1'b0;
            pin_level_o <= 1'b1;
            external_reset_pin_o <= 1'b0;
            external_reset_pin_oe_o <= 1'b0;
        end else begin
            pin_reset_req_o <= next_pin_req;
            pin_level_o <= pin_filt;
            external_reset_pin_o <= 1'b0;
            external_reset_pin_oe_o <= 1'b0;
        end
    end

    // Wake sequencing
    rcwd_state_e state;
    logic [21:0] tmr;
    logic [2:0] cpu_cnt;
    logic cpu_wait;
    logic [5:0] fosc_cnt;
    logic fosc_settling;
    wire skip_ost = primary_clock_idle_i || !is_crystal(primary_mode_i) ||
                    (wake_source_i == RCWD_SRC_PRIMARY);
    wire into_fast = (primary_mode_i == RCWD_OSC_FAST) && (wake_source_i != RCWD_SRC_INTERNAL);
    wire need_pll = (primary_mode_i == RCWD_OSC_HIGH_SPEED_PLL_CRYSTAL);
    wire osc_done = osc_tick_i && (tmr == OST_LAST);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state <= RCWD_ST_IDLE;
            tmr <= 22'h0;
            primary_clock_ready_flag_o <= 1'b0;
        end else begin
            case (state)
                RCWD_ST_IDLE: begin
                    if (event_i.wake && !skip_ost) begin
                        state <= RCWD_ST_OST;
                        tmr <= 22'h0;
                        primary_clock_ready_flag_o <= 1'b0;
                    end else if (event_i.wake && is_crystal(primary_mode_i)) begin
                        primary_clock_ready_flag_o <= 1'b1;
                    end
                end
                RCWD_ST_OST: begin
                    if (osc_tick_i) begin
                        tmr <= tmr + 22'h1;
                    end
                    if (osc_done) begin
                        tmr <= 22'h0;
                        state <= need_pll ? RCWD_ST_PLL : RCWD_ST_DONE;
                    end
                end
                RCWD_ST_PLL: begin
                    tmr <= tmr + 22'h1;
                    if (tmr == PLL_LAST) begin
                        state <= RCWD_ST_DONE;
                    end
                end
                RCWD_ST_DONE: begin
                    primary_clock_ready_flag_o <= 1'b1;
                    state <= RCWD_ST_IDLE;
                end
                default: state <= RCWD_ST_IDLE;
            endcase
        end
    end
    // CPU delay starts at the wake, independent of the oscillator wait
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cpu_wait <= 1'b0;
            cpu_cnt <= 3'h0;
            cpu_run_o <= 1'b1;
        end else if (event_i.wake) begin
            cpu_wait <= 1'b1;
            cpu_cnt <= 3'h0;
            cpu_run_o <= 1'b0;
        end else if (event_i.sleep_instr) begin
            cpu_run_o <= 1'b0;
        end else if (cpu_wait) begin
            cpu_cnt <= cpu_cnt + 3'h1;
            if (cpu_cnt == CPU_LAST) begin
                cpu_wait <= 1'b0;
                cpu_run_o <= 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fosc_settling <= 1'b0;
            fosc_cnt <= 6'h0;
            internal_osc_stable_flag_o <= 1'b0;
        end else if (event_i.wake && into_fast) begin
            fosc_settling <= 1'b1;
            fosc_cnt <= 6'h0;
            internal_osc_stable_flag_o <= 1'b0;
        end else if (fosc_settling) begin
            fosc_cnt <= fosc_cnt + 6'h1;
            if (fosc_cnt == FOSC_LAST) begin
                fosc_settling <= 1'b0;
                internal_osc_stable_flag_o <= 1'b1;
            end
        end
    end

    // Reset cause register; hardware events win over a firmware write
    logic [7:0] cause;
    logic [2:0] fosc_sel;
    wire wr_cause = wr_i && (addr_i == RCWD_OFS_CAUSE);
    wire wr_clock = wr_i && (addr_i == RCWD_OFS_CLOCK);
    wire soft_mode = (brownout_config_mode_i == RCWD_BOR_SOFT_MODE);
    wire bor_active = (brownout_config_mode_i != 2'b00) && (!soft_mode || cause[RCWD_BIT_SOFT_BOR]);
    wire any_reset = |cause_i;
    wire [7:0] cause_view = {cause[7], cause[6] & soft_mode, 1'b0, cause[4:0]};
    wire [7:0] next_rdata = (addr_i == RCWD_OFS_CAUSE) ? cause_view :
                            (addr_i == RCWD_OFS_CLOCK) ? {5'h00, fosc_sel} : 8'h00;
    logic [7:0] next_cause;
    always_comb begin
        next_cause = cause;
        if (wr_cause) begin
            next_cause = {wdata_i[7:6], 1'b0, wdata_i[4:0]};
            next_cause[RCWD_BIT_WDT_EXP] = cause[RCWD_BIT_WDT_EXP];
            next_cause[RCWD_BIT_POWERDOWN] = cause[RCWD_BIT_POWERDOWN];
        end
        if (any_reset) begin
            next_cause[RCWD_BIT_IRQ_PRIO] = 1'b0;
        end
        if (event_i.wdt_clear_instr) begin
            next_cause[RCWD_BIT_WDT_EXP] = 1'b1;
            next_cause[RCWD_BIT_POWERDOWN] = 1'b1;
        end
        if (event_i.sleep_instr) begin
            next_cause[RCWD_BIT_WDT_EXP] = 1'b1;
            next_cause[RCWD_BIT_POWERDOWN] = 1'b0;
        end
        if (event_i.wdt_timeout || cause_i.wdt) begin
            next_cause[RCWD_BIT_WDT_EXP] = 1'b0;
        end
        if (cause_i.reset_instr) begin
            next_cause[RCWD_BIT_RESET_INSTR] = 1'b0;
        end
        if (cause_i.por) begin
            next_cause = RCWD_CAUSE_RESET;
            next_cause[RCWD_BIT_POR] = 1'b0;
            next_cause[RCWD_BIT_BOR] = 1'b0;
        end
        if (cause_i.bor && bor_active) begin
            next_cause[RCWD_BIT_BOR] = 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cause <= RCWD_CAUSE_RESET;
            fosc_sel <= RCWD_FOSC_SEL_RESET;
        end else begin
            cause <= next_cause;
            if (any_reset) begin
                fosc_sel <= RCWD_FOSC_SEL_RESET;
            end else if (wr_clock) begin
                fosc_sel <= wdata_i[2:0];
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
            soft_brownout_enable_o <= 1'b0;
            irq_priority_enable_o <= 1'b0;
            fast_osc_sel_o <= RCWD_FOSC_SEL_RESET;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
            soft_brownout_enable_o <= cause[RCWD_BIT_SOFT_BOR] & soft_mode;
            irq_priority_enable_o <= cause[RCWD_BIT_IRQ_PRIO];
            fast_osc_sel_o <= fosc_sel;
        end
    end

    property p_no_pin_drive;
        @(posedge clock_i) disable iff (srst_i) !external_reset_pin_oe_o;
    endproperty
    a_no_pin_drive: assert property (p_no_pin_drive) else $error("reset pin driven");
    property p_bit5_zero;
        @(posedge clock_i) disable iff (srst_i) rd_i && addr_i == RCWD_OFS_CAUSE |=> !rdata_o[5];
    endproperty
    a_bit5_zero: assert property (p_bit5_zero) else $error("bit 5 not zero");
    property p_soft_bor_zero;
        @(posedge clock_i) disable iff (srst_i)
            rd_i && addr_i == RCWD_OFS_CAUSE && !soft_mode |=> !rdata_o[6];
    endproperty
    a_soft_bor_zero: assert property (p_soft_bor_zero) else $error("bit 6 visible outside mode 01");
    property p_por_clears;
        @(posedge clock_i) disable iff (srst_i) cause_i.por |=> !cause[RCWD_BIT_POR] && !cause[RCWD_BIT_BOR];
    endproperty
    a_por_clears: assert property (p_por_clears) else $error("power-on did not clear bits");
    property p_sleep_pd;
        @(posedge clock_i) disable iff (srst_i)
            event_i.sleep_instr && !cause_i.por |=> !cause[RCWD_BIT_POWERDOWN];
    endproperty
    a_sleep_pd: assert property (p_sleep_pd) else $error("sleep did not clear powerdown");
    property p_wdt_to;
        @(posedge clock_i) disable iff (srst_i)
            event_i.wdt_timeout && !cause_i.por |=> !cause[RCWD_BIT_WDT_EXP];
    endproperty
    a_wdt_to: assert property (p_wdt_to) else $error("timeout did not clear flag");
    // A sleep during the delay freezes the count, so such wakes are not judged here
    sequence s_wake_quiet;
        event_i.wake ##1 (!event_i.wake && !event_i.sleep_instr) [*4];
    endsequence
    property p_cpu_delay;
        @(posedge clock_i) disable iff (srst_i) s_wake_quiet |=> cpu_run_o && !$past(cpu_run_o);
    endproperty
    a_cpu_delay: assert property (p_cpu_delay) else $error("cpu wake delay wrong");
    property p_skip_ost;
        @(posedge clock_i) disable iff (srst_i)
            state == RCWD_ST_IDLE && event_i.wake && skip_ost |=> state == RCWD_ST_IDLE;
    endproperty
    a_skip_ost: assert property (p_skip_ost) else $error("start-up count ran when skipped");
    property p_ri_clear;
        @(posedge clock_i) disable iff (srst_i)
            cause_i.reset_instr && !cause_i.por |=> !cause[RCWD_BIT_RESET_INSTR];
    endproperty
    a_ri_clear: assert property (p_ri_clear) else $error("reset instr flag not cleared");
    property p_bor_clear;
        @(posedge clock_i) disable iff (srst_i) cause_i.bor && bor_active |=> !cause[RCWD_BIT_BOR];
    endproperty
    a_bor_clear: assert property (p_bor_clear) else $error("brown-out flag not cleared");
    property p_irq_clear;
        @(posedge clock_i) disable iff (srst_i) any_reset |=> !cause[RCWD_BIT_IRQ_PRIO];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("priority enable kept");
    property p_fosc_default;
        @(posedge clock_i) disable iff (srst_i) any_reset |=> fosc_sel == RCWD_FOSC_SEL_RESET;
    endproperty
    a_fosc_default: assert property (p_fosc_default) else $error("fast select not restored");
    property p_clr_sets;
        @(posedge clock_i) disable iff (srst_i)
            event_i.wdt_clear_instr && !event_i.sleep_instr && !event_i.wdt_timeout && !cause_i.wdt
            |=> cause[RCWD_BIT_WDT_EXP] && cause[RCWD_BIT_POWERDOWN];
    endproperty
    a_clr_sets: assert property (p_clr_sets) else $error("watchdog clear did not set flags");
    property p_fast_stable;
        @(posedge clock_i) disable iff (srst_i)
            fosc_settling && fosc_cnt == FOSC_LAST && !(event_i.wake && into_fast) |=> internal_osc_stable_flag_o;
    endproperty
    a_fast_stable: assert property (p_fast_stable) else $error("stable flag late");
    sequence s_ready_next;
        state == RCWD_ST_DONE ##1 primary_clock_ready_flag_o;
    endsequence
    property p_pll_end;
        @(posedge clock_i) disable iff (srst_i) state == RCWD_ST_PLL && tmr == PLL_LAST |=> s_ready_next;
    endproperty
    a_pll_end: assert property (p_pll_end) else $error("lock wait end wrong");
    property p_ost_end;
        @(posedge clock_i) disable iff (srst_i) state == RCWD_ST_OST && osc_done && !need_pll |=> s_ready_next;
    endproperty
    a_ost_end: assert property (p_ost_end) else $error("start-up end wrong");
    property p_ost_hold;
        @(posedge clock_i) disable iff (srst_i)
            state == RCWD_ST_OST && !osc_done |=> state == RCWD_ST_OST && !primary_clock_ready_flag_o;
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("start-up left early");
    property p_pin_req;
        @(posedge clock_i) disable iff (srst_i) external_reset_pin_enable_i && !pin_filt |=> pin_reset_req_o;
    endproperty
    a_pin_req: assert property (p_pin_req) else $error("pin request missing");
    property p_pin_off;
        @(posedge clock_i) disable iff (srst_i) !external_reset_pin_enable_i |=> !pin_reset_req_o;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled pin requested reset");
    property p_filter_hold;
        @(posedge clock_i) disable iff (srst_i) !pin_differs |=> $stable(pin_filt);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("filtered pin moved early");
endmodule : rcwd_top

// File: dv/rcwd_pin_model.sv
`timescale 1ns/10ps
module rcwd_pin_model (
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic [7:0] len_i,
    output logic pin_n_o
);
    logic [7:0] left = 8'h00;
    // Pull-up: the pin rests high whenever nobody holds it low
    assign pin_n_o = (left == 8'h00);
    always @(posedge clock_i) begin
        if (start_i) begin
            left <= len_i;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
endmodule : rcwd_pin_model

// File: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    import rcwd_pkg::*;
    // Short lock wait keeps the run brief
    localparam int PLL = 20;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic osc_tick_i = 1'b0;
    rcwd_osc_e mode = RCWD_OSC_HS;
    rcwd_src_e src = RCWD_SRC_PRIMARY;
    logic idle = 1'b0;
    rcwd_event_s ev = '0;
    rcwd_cause_s cause = '0;
    logic [1:0] bmode = 2'b11;
    logic pin_en = 1'b1;
    logic pin_start = 1'b0;
    logic [7:0] pin_len = 8'h00;
    logic [7:0] rdata, d;
    logic [2:0] fsel;
    logic pin_n, pin_oe, pin_out, pin_req, pin_lvl, cpu_run, pri_rdy, fast_ok, sbor, irq_pe;
    int n_fail = 0;
    int cmp_count = 0;

    rcwd_top #(.PLL_CYCLES(PLL), .PIN_FILTER(RCWD_PIN_FILTER_CYCLES)) dut_u (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata), .osc_tick_i(osc_tick_i), .primary_mode_i(mode),
        .wake_source_i(src), .primary_clock_idle_i(idle), .event_i(ev), .cause_i(cause),
        .brownout_config_mode_i(bmode), .external_reset_pin_enable_i(pin_en),
        .external_reset_pin_n_i(pin_n), .external_reset_pin_o(pin_out),
        .external_reset_pin_oe_o(pin_oe), .pin_reset_req_o(pin_req), .pin_level_o(pin_lvl),
        .cpu_run_o(cpu_run), .primary_clock_ready_flag_o(pri_rdy),
        .internal_osc_stable_flag_o(fast_ok), .soft_brownout_enable_o(sbor),
        .irq_priority_enable_o(irq_pe), .fast_osc_sel_o(fsel));

    rcwd_pin_model pin_u (.clock_i(clock_i), .start_i(pin_start), .len_i(pin_len), .pin_n_o(pin_n));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask : check

    task automatic chk1(input string w, input logic e, input logic g);
        check(w, {7'h0, e}, {7'h0, g});
    endtask : chk1

    task automatic do_reset;
        @(posedge clock_i);
        srst_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rdchk(input string w, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        check(w, e, rdata & m);
    endtask : rdchk

    task automatic pulse(input rcwd_event_s e, input rcwd_cause_s c);
        @(posedge clock_i);
        ev <= e;
        cause <= c;
        @(posedge clock_i);
        ev <= '0;
        cause <= '0;
    endtask : pulse

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock_i);
            osc_tick_i <= 1'b1;
            @(posedge clock_i);
            osc_tick_i <= 1'b0;
            repeat (int'($urandom_range(1, 0))) @(posedge clock_i);
        end
        @(negedge clock_i);
    endtask : ticks

    // Bits 3 and 2 only move on events, so writes must leave them set
    function automatic logic [7:0] exp_cause(input logic [7:0] v, input logic [1:0] m);
        return {v[7], v[6] & (m == RCWD_BOR_SOFT_MODE), 1'b0, v[4], 2'b11, v[1:0]};
    endfunction : exp_cause

    task automatic wake_case(input rcwd_osc_e m, input rcwd_src_e s, input logic il, input logic osc_startup_timer,
                             input logic pll);
        int k;
        logic low;
        do_reset();
        mode <= m;
        src <= s;
        idle <= il;
        pulse(4'h8, '0);
        low = 1'b0;
        for (k = 0; k < 10 && !(low && cpu_run === 1'b1); k++) begin
            @(negedge clock_i);
            low = low | (cpu_run === 1'b0);
        end
        chk1("cpu_resume", 1'b1, low && k == RCWD_CPU_WAKE_CYCLES + 1);
        if (m == RCWD_OSC_FAST) begin
            repeat (RCWD_FOSC_SETTLE_CYCLES - 12) @(negedge clock_i);
            chk1("fast_ok", 1'b0, fast_ok);
            for (k = 0; k < 16 && fast_ok !== 1'b1; k++) @(negedge clock_i);
            chk1("fast_ok", 1'b1, fast_ok);
        end else if (osc_startup_timer) begin
            chk1("pri_rdy", 1'b0, pri_rdy);
            ticks(RCWD_OST_CYCLES - 1);
            chk1("pri_rdy", 1'b0, pri_rdy);
            ticks(1);
            if (pll) begin
                repeat (PLL - 4) @(negedge clock_i);
                chk1("pri_rdy", 1'b0, pri_rdy);
            end
            for (k = 0; k < 16 && pri_rdy !== 1'b1; k++) @(negedge clock_i);
            chk1("pri_rdy", 1'b1, pri_rdy);
        end else if (il) begin
            chk1("primary_clock_idle", 1'b1, pri_rdy);
        end
        $display("test wake mode %0d done", m);
    endtask : wake_case

    task automatic pin_case(input logic en, input logic lng);
        logic req;
        logic lvl;
        @(posedge clock_i);
        pin_en <= en;
        pin_start <= 1'b1;
        pin_len <= lng ? 8'($urandom_range(20, 10)) : 8'($urandom_range(3, 1));
        @(posedge clock_i);
        pin_start <= 1'b0;
        req = 1'b0;
        lvl = 1'b1;
        repeat (40) begin
            @(negedge clock_i);
            req = req | (pin_req === 1'b1);
            lvl = lvl & (pin_lvl !== 1'b0);
            check("pin_drive", 8'h00, {6'h0, pin_oe, pin_out});
        end
        chk1("pin_req", lng & en, req);
        chk1("pin_lvl", !lng, lvl);
        chk1("pin_req_end", 1'b0, pin_req);
        $display("test pin en %0b long %0b done", en, lng);
    endtask : pin_case

    initial begin
        void'($urandom(32'h2da5_4fb8));
        do_reset();
        rdchk("cause", RCWD_OFS_CAUSE, 8'hff, RCWD_CAUSE_RESET & 8'hbf);
        rdchk("fsel", RCWD_OFS_CLOCK, 8'h07, {5'h0, RCWD_FOSC_SEL_RESET});
        chk1("irq_pe", 1'b0, irq_pe);
        for (int i = 0; i < 12; i++) begin
            @(posedge clock_i);
            bmode <= (i == 0) ? RCWD_BOR_SOFT_MODE : 2'($urandom);
            d = 8'($urandom);
            wr(RCWD_OFS_CAUSE, d);
            wr(4'h8 | 4'($urandom), ~d);
            rdchk("cause", RCWD_OFS_CAUSE, 8'hff, exp_cause(d, bmode));
            chk1("irq_pe", d[7], irq_pe);
            chk1("sbor", d[6] & (bmode == RCWD_BOR_SOFT_MODE), sbor);
            rdchk("unmapped", 4'h8 | 4'($urandom), 8'hff, 8'h00);
        end
        $display("test registers done");
        @(posedge clock_i);
        bmode <= 2'b11;
        wr(RCWD_OFS_CAUSE, 8'hff);
        pulse(4'h4, '0);
        rdchk("sleep", RCWD_OFS_CAUSE, 8'h0c, 8'h08);
        pulse(4'h1, '0);
        rdchk("timeout", RCWD_OFS_CAUSE, 8'h0c, 8'h00);
        pulse(4'h2, '0);
        rdchk("wdt_clear", RCWD_OFS_CAUSE, 8'h0c, 8'h0c);
        pulse('0, 8'h04);
        rdchk("reset_instr", RCWD_OFS_CAUSE, 8'h10, 8'h00);
        wr(RCWD_OFS_CAUSE, 8'hff);
        rdchk("reset_instr_set", RCWD_OFS_CAUSE, 8'h10, 8'h10);
        pulse('0, 8'h80);
        rdchk("por", RCWD_OFS_CAUSE, 8'h03, 8'h00);
        wr(RCWD_OFS_CAUSE, 8'h13);
        pulse('0, 8'h40);
        rdchk("bor", RCWD_OFS_CAUSE, 8'h03, 8'h02);
        for (int i = 0; i < 8; i++) begin
            wr(RCWD_OFS_CLOCK, 8'h01);
            wr(RCWD_OFS_CAUSE, 8'h80);
            pulse('0, 8'(8'h01 << i));
            repeat (2) @(negedge clock_i);
            check("fsel", {5'h0, RCWD_FOSC_SEL_RESET}, {5'h0, fsel});
            chk1("irq_pe", 1'b0, irq_pe);
        end
        $display("test events done");
        wake_case(RCWD_OSC_LP, RCWD_SRC_SECONDARY, 1'b0, 1'b1, 1'b0);
        wake_case(RCWD_OSC_XT, RCWD_SRC_INTERNAL, 1'b0, 1'b1, 1'b0);
        wake_case(RCWD_OSC_HS, RCWD_SRC_NONE, 1'b0, 1'b1, 1'b0);
        wake_case(RCWD_OSC_HIGH_SPEED_PLL_CRYSTAL, RCWD_SRC_NONE, 1'b0, 1'b1, 1'b1);
        wake_case(RCWD_OSC_HS, RCWD_SRC_PRIMARY, 1'b1, 1'b0, 1'b0);
        wake_case(RCWD_OSC_EXT, RCWD_SRC_NONE, 1'b0, 1'b0, 1'b0);
        wake_case(RCWD_OSC_RC, RCWD_SRC_SECONDARY, 1'b0, 1'b0, 1'b0);
        wake_case(RCWD_OSC_FAST, RCWD_SRC_SECONDARY, 1'b0, 1'b0, 1'b0);
        pin_case(1'b1, 1'b0);
        pin_case(1'b1, 1'b1);
        pin_case(1'b0, 1'b1);
        complete_run();
    end

    initial begin
        #(25 * 40000);
        n_fail++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end
endmodule : testbench
